// file: rtl/sdg_pkg.sv
// Shared constants for the 40-bit serial datagram link and its two ends.
package sdg_pkg;

  // Datagram layout.
  localparam int unsigned FRAME_BITS = 40;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 7;
  localparam int unsigned STAT_W = 8;
  localparam int unsigned FLAG_W = 4;
  localparam int unsigned WRITE_BIT = 39;
  localparam int unsigned ADDR_LSB = 32;
  localparam int unsigned CNT_W = 6;
  localparam logic [7:0] WRITE_ADDR_OFFSET = 8'h80;
  localparam logic [STAT_W-FLAG_W-1:0] STAT_UNUSED = 4'h0;

  // System clock and input filter timing.
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned FILT_NS = 20;
  localparam int unsigned FILT_CYC = (FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Host clock divider: half bus clock period in system cycles, idle gap in half bus clock periods.
  localparam int unsigned SCK_HALF_CYC = 4;
  localparam int unsigned SDO_SYNC_CYC = 2;
  localparam int unsigned CS_GAP_HALVES = 3;

  // Idle levels of the filtered device pins {driver_disable_input, chip_select_low}.
  localparam logic [1:0] PIN_IDLE = 2'h3;

endpackage : sdg_pkg

// file: rtl/sdg_link_if.sv
// Four-wire serial link between the host end and the device end.
`timescale 1ns/1ns
`default_nettype none
interface sdg_link_if;
  logic chip_select_low;
  logic sck;
  logic sdi;
  logic sdo;

  modport dev (
    input chip_select_low,
    input sck,
    input sdi,
    output sdo
  );

  modport host (
    output chip_select_low,
    output sck,
    output sdi,
    input sdo
  );
endinterface : sdg_link_if
`default_nettype wire

// file: rtl/sdg_device_end.sv
// Device end of the datagram link: shift register, command latch and reply.
`timescale 1ns/1ns
`default_nettype none
module sdg_device_end #(
  parameter int unsigned FILT_CYC = sdg_pkg::FILT_CYC
) (
  // System clock and reset.
  input wire logic clock,
  input wire logic rst,
  // Serial link, clocked by the bus clock.
  sdg_link_if.dev link,
  // Latched command towards the register file.
  output logic cmd_valid,
  output logic cmd_write,
  output logic [sdg_pkg::ADDR_W-1:0] cmd_addr,
  output logic [sdg_pkg::DATA_W-1:0] cmd_data,
  // Register file answer and status flags for the next reply.
  input wire logic [sdg_pkg::DATA_W-1:0] read_data,
  input wire logic [sdg_pkg::FLAG_W-1:0] status_flags,
  // Driver disable pin and its filtered level.
  input wire logic driver_disable_input,
  output logic driver_disabled
);
  import sdg_pkg::*;

  localparam int unsigned FC_W = $clog2(FILT_CYC + 1);

  // ---------------------------------------------------------------
  // Link domain. Bit counter and output flop are cleared while the
  // chip is deselected, so a frame always starts from a known state
  // even though the bus clock does not run between frames.
  // ---------------------------------------------------------------
  logic [CNT_W-1:0] bit_cnt_q;
  logic [FRAME_BITS-1:0] shift_q;
  logic sdo_q;
  logic [FRAME_BITS-1:0] reply_q;

  wire cnt_full = (bit_cnt_q == CNT_W'(FRAME_BITS));
  wire [CNT_W-1:0] reply_idx = CNT_W'(FRAME_BITS - 1) - bit_cnt_q;
  wire reply_bit = reply_q[reply_idx];
  wire chain_bit = shift_q[FRAME_BITS-1];
  wire out_bit = cnt_full ? chain_bit : reply_bit;

  always_ff @(posedge link.sck or posedge link.chip_select_low) begin
    if (link.chip_select_low) begin
      bit_cnt_q <= '0;
    end else if (!cnt_full) begin
      bit_cnt_q <= bit_cnt_q + 1'b1;
    end
  end

  // Incoming bits enter at the bottom, so the oldest of the last forty
  // sits at the top and the register always holds the final forty.
  always_ff @(posedge link.sck) begin
    shift_q <= {shift_q[FRAME_BITS-2:0], link.sdi};
  end

  // The first falling edge of a mode 3 frame comes before the first
  // rising edge, so the top reply bit is out in time to be sampled.
  always_ff @(negedge link.sck or posedge link.chip_select_low) begin
    if (link.chip_select_low) begin
      sdo_q <= 1'b0;
    end else begin
      sdo_q <= out_bit;
    end
  end

  assign link.sdo = sdo_q;

  // ---------------------------------------------------------------
  // System domain: synchronise and filter select and driver disable.
  // ---------------------------------------------------------------
  wire [1:0] pin_raw = {driver_disable_input, link.chip_select_low};
  logic [1:0] pin_filt;

  for (genvar i = 0; i < 2; i++) begin : g_pin
    logic meta_q;
    logic sync_q;
    logic filt_q;
    logic [FC_W-1:0] run_q;

    wire differs = (sync_q != filt_q);
    wire settled = (run_q == FC_W'(FILT_CYC - 1));

    always_ff @(posedge clock) begin
      if (rst) begin
        meta_q <= PIN_IDLE[i];
        sync_q <= PIN_IDLE[i];
      end else begin
        meta_q <= pin_raw[i];
        sync_q <= meta_q;
      end
    end

    // A new level is taken only after it has held for the filter time.
    always_ff @(posedge clock) begin
      if (rst) begin
        filt_q <= PIN_IDLE[i];
        run_q <= '0;
      end else if (!differs) begin
        run_q <= '0;
      end else if (settled) begin
        filt_q <= sync_q;
        run_q <= '0;
      end else begin
        run_q <= run_q + 1'b1;
      end
    end

    assign pin_filt[i] = filt_q;
  end

  wire cs_filt = pin_filt[0];
  wire enn_filt = pin_filt[1];

  logic cs_prev_q;
  wire cs_rise = cs_filt & ~cs_prev_q;

  always_ff @(posedge clock) begin
    if (rst) begin
      cs_prev_q <= PIN_IDLE[0];
    end else begin
      cs_prev_q <= cs_filt;
    end
  end

  // ---------------------------------------------------------------
  // Command latch. The shift register is read here only after the
  // filtered select has risen; the bus clock is idle by then, so the
  // word is stable across the crossing.
  // ---------------------------------------------------------------
  logic cmd_valid_q;
  logic cmd_write_q;
  logic [ADDR_W-1:0] cmd_addr_q;
  logic [DATA_W-1:0] cmd_data_q;

  wire frame_write = shift_q[WRITE_BIT];
  wire [ADDR_W-1:0] frame_addr = shift_q[ADDR_LSB +: ADDR_W];
  wire [DATA_W-1:0] frame_data = shift_q[DATA_W-1:0];

  always_ff @(posedge clock) begin
    if (rst) begin
      cmd_valid_q <= 1'b0;
      cmd_write_q <= 1'b0;
      cmd_addr_q <= '0;
      cmd_data_q <= '0;
    end else begin
      cmd_valid_q <= cs_rise;
      if (cs_rise) begin
        cmd_write_q <= frame_write;
        cmd_addr_q <= frame_addr;
        cmd_data_q <= frame_data;
      end
    end
  end

  assign cmd_valid = cmd_valid_q;
  assign cmd_write = cmd_write_q;
  assign cmd_addr = cmd_addr_q;
  assign cmd_data = cmd_data_q;

  // ---------------------------------------------------------------
  // Reply for the next frame. It changes only while the chip is
  // deselected, which is what lets the link domain read it directly.
  // ---------------------------------------------------------------
  wire [DATA_W-1:0] reply_data = cmd_write_q ? cmd_data_q : read_data;
  wire [STAT_W-1:0] reply_status = {STAT_UNUSED, status_flags};

  always_ff @(posedge clock) begin
    if (rst) begin
      reply_q <= '0;
    end else if (cmd_valid_q) begin
      reply_q <= {reply_status, reply_data};
    end
  end

  // ---------------------------------------------------------------
  // Driver disable level after filtering.
  // ---------------------------------------------------------------
  logic driver_disabled_q;

  always_ff @(posedge clock) begin
    if (rst) begin
      driver_disabled_q <= PIN_IDLE[1];
    end else begin
      driver_disabled_q <= enn_filt;
    end
  end

  assign driver_disabled = driver_disabled_q;

endmodule : sdg_device_end
`default_nettype wire

// file: rtl/sdg_host_end.sv
// Host end of the datagram link: builds a datagram and clocks it out in mode 3.
`timescale 1ns/1ns
`default_nettype none
module sdg_host_end #(
  parameter int unsigned SCK_HALF = sdg_pkg::SCK_HALF_CYC,
  parameter int unsigned GAP_HALVES = sdg_pkg::CS_GAP_HALVES
) (
  // System clock and reset.
  input wire logic clock,
  input wire logic rst,
  // Serial link; the bus clock is made here.
  sdg_link_if.host link,
  // Request.
  input wire logic req_start,
  input wire logic req_write,
  input wire logic [sdg_pkg::ADDR_W-1:0] req_addr,
  input wire logic [sdg_pkg::DATA_W-1:0] req_data,
  // Status and reply.
  output logic busy,
  output logic done,
  output logic [sdg_pkg::STAT_W-1:0] reply_status,
  output logic [sdg_pkg::DATA_W-1:0] reply_data
);
  import sdg_pkg::*;

  localparam int unsigned TW = $clog2(SCK_HALF + 1);
  localparam int unsigned BW = $clog2(FRAME_BITS + GAP_HALVES + 1);

  typedef enum logic [2:0] {
    SDGH_IDLE,
    SDGH_LEAD,
    SDGH_LOW,
    SDGH_HIGH,
    SDGH_TAIL,
    SDGH_GAP
  } sdg_host_state_t;

  sdg_host_state_t state_q;
  logic [TW-1:0] timer_q;
  logic [BW-1:0] bits_q;
  logic [FRAME_BITS-1:0] tx_q;
  logic [FRAME_BITS-1:0] rx_q;
  logic cs_n_q;
  logic sck_q;
  logic sdi_q;
  logic sdo_meta_q;
  logic sdo_sync_q;
  logic busy_q;
  logic done_q;
  logic [FRAME_BITS-1:0] reply_q;

  // The write flag is the top bit of the address byte, i.e. address plus 0x80.
  wire [7:0] addr_byte = {1'b0, req_addr} | (req_write ? WRITE_ADDR_OFFSET : 8'h00);
  wire [FRAME_BITS-1:0] frame = {addr_byte, req_data};
  // Half period of the bus clock; well under half of the device clock.
  wire tick = (timer_q == TW'(SCK_HALF - 1));
  wire last_bit = (bits_q == BW'(FRAME_BITS));
  wire gap_over = (bits_q == BW'(GAP_HALVES - 1));

  always_ff @(posedge clock) begin
    if (rst || state_q == SDGH_IDLE || tick) begin
      timer_q <= '0;
    end else begin
      timer_q <= timer_q + 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      sdo_meta_q <= 1'b0;
      sdo_sync_q <= 1'b0;
    end else begin
      sdo_meta_q <= link.sdo;
      sdo_sync_q <= sdo_meta_q;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_q <= SDGH_IDLE;
      bits_q <= '0;
      tx_q <= '0;
      rx_q <= '0;
      cs_n_q <= 1'b1;
      sck_q <= 1'b1;
      sdi_q <= 1'b0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      reply_q <= '0;
    end else begin
      done_q <= 1'b0;
      case (state_q)
        SDGH_IDLE: begin
          if (req_start) begin
            cs_n_q <= 1'b0;
            tx_q <= frame;
            sdi_q <= frame[FRAME_BITS-1];
            bits_q <= '0;
            busy_q <= 1'b1;
            state_q <= SDGH_LEAD;
          end
        end
        SDGH_LEAD: begin
          if (tick) begin
            sck_q <= 1'b0;
            state_q <= SDGH_LOW;
          end
        end
        SDGH_LOW: begin
          if (tick) begin
            sck_q <= 1'b1;
            rx_q <= {rx_q[FRAME_BITS-2:0], sdo_sync_q};
            tx_q <= {tx_q[FRAME_BITS-2:0], 1'b0};
            bits_q <= bits_q + 1'b1;
            state_q <= SDGH_HIGH;
          end
        end
        SDGH_HIGH: begin
          if (tick) begin
            if (last_bit) begin
              state_q <= SDGH_TAIL;
            end else begin
              sck_q <= 1'b0;
              sdi_q <= tx_q[FRAME_BITS-1];
              state_q <= SDGH_LOW;
            end
          end
        end
        SDGH_TAIL: begin
          if (tick) begin
            cs_n_q <= 1'b1;
            reply_q <= rx_q;
            done_q <= 1'b1;
            bits_q <= '0;
            state_q <= SDGH_GAP;
          end
        end
        SDGH_GAP: begin
          if (tick) begin
            if (gap_over) begin
              busy_q <= 1'b0;
              state_q <= SDGH_IDLE;
            end else begin
              bits_q <= bits_q + 1'b1;
            end
          end
        end
        default: begin
          state_q <= SDGH_IDLE;
        end
      endcase
    end
  end

  assign link.chip_select_low = cs_n_q;
  assign link.sck = sck_q;
  assign link.sdi = sdi_q;
  assign busy = busy_q;
  assign done = done_q;
  assign reply_status = reply_q[FRAME_BITS-1 -: STAT_W];
  assign reply_data = reply_q[DATA_W-1:0];

endmodule : sdg_host_end
`default_nettype wire

// file: sim/sdg_link_monitor.sv
// Concurrent checks on the four wires between host end and device end.
`timescale 1ns/1ns
`default_nettype none
module sdg_link_monitor (
  // System clock and reset.
  input wire logic clock,
  input wire logic rst,
  // Link wires.
  input wire logic chip_select_low,
  input wire logic sck,
  input wire logic sdi,
  input wire logic sdo
);
  logic [7:0] rises_q;
  logic [7:0] rises_d;

  // Counts bus clock rising edges within one selected period.
  assign rises_d = rises_q + 8'h01;
  always_ff @(posedge clock) begin
    if (rst || chip_select_low) begin
      rises_q <= 8'h00;
    end else if ($rose(sck)) begin
      rises_q <= rises_d;
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  idle_clock_high_a: assert property (chip_select_low |-> sck)
    else $error("bus clock low while deselected");
  out_quiet_a: assert property (chip_select_low && $past(chip_select_low) |-> !sdo)
    else $error("data output driven while deselected");
  first_fall_a: assert property ($fell(chip_select_low) |-> sck [*4] ##1 !sck)
    else $error("first bus clock fall misplaced");
  clock_low_a: assert property ($fell(sck) |-> !sck [*4] ##1 sck)
    else $error("bus clock low phase wrong");
  clock_high_a: assert property ($rose(sck) && !chip_select_low && rises_q != 8'h27
    |-> sck [*4] ##1 !sck)
    else $error("bus clock high phase wrong");
  tail_hold_a: assert property ($rose(sck) && !chip_select_low && rises_q == 8'h27
    |-> sck [*8] ##1 chip_select_low)
    else $error("select not released after the last bit");
  data_on_fall_a: assert property (!chip_select_low && $changed(sdi)
    |-> $fell(sck) || $fell(chip_select_low))
    else $error("data input changed outside a falling edge");
  out_steady_a: assert property (!chip_select_low && !$past(chip_select_low) && sck
    && $past(sck) |-> $stable(sdo))
    else $error("data output changed while bus clock high");
  forty_clocks_a: assert property ($rose(chip_select_low) |-> rises_q == 8'h28)
    else $error("frame not forty clocks long");
  select_gap_a: assert property ($rose(chip_select_low) |-> chip_select_low [*8])
    else $error("select high gap too short");
  reset_idle_a: assert property (disable iff (1'h0) rst |=> chip_select_low && sck)
    else $error("link not idle after reset");
endmodule : sdg_link_monitor
`default_nettype wire

// file: sim/spi_slave_40bit_datagram_test.sv
// Self-checking bench: host end against device end, plus a bench-driven chained frame.
`timescale 1ns/1ns
`default_nettype none
module spi_slave_40bit_datagram_test;
  import sdg_pkg::*;
  logic clock = 1'h0;
  logic rst = 1'h1;
  logic req_start = 1'h0;
  logic req_write = 1'h0;
  logic [ADDR_W-1:0] req_addr = 7'h00;
  logic [DATA_W-1:0] req_data = 32'h0;
  logic [DATA_W-1:0] read_data = 32'h0;
  logic [FLAG_W-1:0] status_flags = 4'h0;
  logic driver_disable_input = 1'h0;
  logic busy, done, cmd_valid, cmd_write, driver_disabled, c2_valid, c2_write;
  logic [STAT_W-1:0] reply_status;
  logic [DATA_W-1:0] reply_data, cmd_data, c2_data;
  logic [ADDR_W-1:0] cmd_addr, c2_addr;
  logic [39:0] mosi, miso;
  int n_mismatch = 0;
  int comparisons = 0;
  sdg_link_if link ();
  sdg_link_if l2 ();

  sdg_host_end i_sdg_host_end (.clock(clock), .rst(rst), .link(link.host),
    .req_start(req_start), .req_write(req_write), .req_addr(req_addr), .req_data(req_data),
    .busy(busy), .done(done), .reply_status(reply_status), .reply_data(reply_data));
  sdg_device_end i_sdg_device_end (.clock(clock), .rst(rst), .link(link.dev),
    .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
    .read_data(read_data), .status_flags(status_flags),
    .driver_disable_input(driver_disable_input), .driver_disabled(driver_disabled));
  sdg_device_end i_sdg_device_end_2 (.clock(clock), .rst(rst), .link(l2.dev),
    .cmd_valid(c2_valid), .cmd_write(c2_write), .cmd_addr(c2_addr), .cmd_data(c2_data),
    .read_data(32'h0), .status_flags(4'h0), .driver_disable_input(1'h0), .driver_disabled());
  sdg_link_monitor i_sdg_link_monitor (.clock(clock), .rst(rst),
    .chip_select_low(link.chip_select_low), .sck(link.sck), .sdi(link.sdi), .sdo(link.sdo));

  initial begin
    forever #5 clock = ~clock;
  end

  // A deselect edge clears the bit counter and output flop of the second device end, which rst cannot reach.
  initial begin
    l2.chip_select_low = 1'h0;
    l2.sck = 1'h1;
    l2.sdi = 1'h0;
    #1;
    l2.chip_select_low = 1'h1;
  end

  // Mode 3: both directions are taken on the bus clock rising edge.
  always @(posedge link.sck) if (!link.chip_select_low) begin
    mosi <= {mosi[38:0], link.sdi};
    miso <= {miso[38:0], link.sdo};
  end

  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Waits on one handshake output: 0 done, 1 cmd_valid, 2 busy, 3 c2_valid.
  task automatic wait_for(input int unsigned which, input logic val, input int lim);
    logic now_v;
    repeat (lim) begin
      @(negedge clock);
      now_v = (which == 0) ? done : (which == 1) ? cmd_valid : (which == 2) ? busy : c2_valid;
      if (now_v === val) begin
        return;
      end
    end
    n_mismatch++;
    $display("MISMATCH at %0t: wait ran out", $time);
    wrap_up();
  endtask : wait_for

  task automatic xfer(input logic w, input logic [6:0] a, input logic [31:0] d,
      input logic [39:0] rep);
    @(negedge clock);
    req_start = 1'h1;
    req_write = w;
    req_addr = a;
    req_data = d;
    @(negedge clock);
    req_start = 1'h0;
    wait_for(0, 1'h1, 400);
    chk({reply_status, reply_data}, rep);
    chk(miso, rep);
    chk(mosi, {w, a, d});
    chk(mosi[39:32], {1'h0, a} + (w ? WRITE_ADDR_OFFSET : 8'h00));
    wait_for(1, 1'h1, 12);
    chk({cmd_write, cmd_addr, cmd_data}, {w, a, d});
    wait_for(2, 1'h0, 40);
  endtask : xfer

  task automatic t_reset;
    chk({cmd_valid, cmd_write, cmd_addr, cmd_data}, 40'h0);
    chk({busy, done, reply_status, reply_data}, 40'h0);
  endtask : t_reset

  task automatic t_write_pair;
    status_flags = 4'h5;
    xfer(1'h1, 7'h6C, 32'h00ABCDEF, 40'h0);
    status_flags = 4'hA;
    xfer(1'h1, 7'h6C, 32'h00123456, {8'h05, 32'h00ABCDEF});
  endtask : t_write_pair

  task automatic t_read_pipe;
    read_data = 32'hCAFE0001;
    status_flags = 4'h3;
    xfer(1'h0, 7'h6F, 32'h0, {8'h0A, 32'h00123456});
    read_data = 32'h0BAD0002;
    xfer(1'h0, 7'h00, 32'hFFFFFFFF, {8'h03, 32'hCAFE0001});
  endtask : t_read_pipe

  task automatic t_filter;
    @(negedge clock);
    driver_disable_input = 1'h1;
    @(negedge clock);
    driver_disable_input = 1'h0;
    repeat (6) @(negedge clock);
    chk(driver_disabled, 1'h0);
    driver_disable_input = 1'h1;
    repeat (8) @(negedge clock);
    chk(driver_disabled, 1'h1);
  endtask : t_filter

  // Eight bits beyond a frame on the second link, with a 32 ns bus clock.
  task automatic t_chain;
    logic [47:0] p;
    logic [47:0] got;
    p = 48'h5A9387654321;
    got = 48'h0;
    l2.chip_select_low = 1'h0;
    #16;
    for (int i = 47; i >= 0; i--) begin
      l2.sck = 1'h0;
      l2.sdi = p[i];
      #16;
      l2.sck = 1'h1;
      got = {got[46:0], l2.sdo};
      #16;
    end
    l2.chip_select_low = 1'h1;
    l2.sdi = ~p[0];
    chk(got[7:0], p[47:40]);
    chk(got[47:8], 40'h0);
    wait_for(3, 1'h1, 20);
    chk({c2_write, c2_addr, c2_data}, p[39:0]);
  endtask : t_chain

  initial begin
    repeat (16) @(negedge clock);
    rst = 1'h0;
    t_reset();
    t_write_pair();
    t_read_pipe();
    t_filter();
    t_chain();
    wrap_up();
  end
endmodule : spi_slave_40bit_datagram_test
`default_nettype wire
